// [src/osr_params.svh]
// constants for the operation sub-status register bank
`ifndef OSR_PARAMS_SVH
`define OSR_PARAMS_SVH
`define OSR_REG_W        16
`define OSR_ACTIVE_BIT   1
`define OSR_NUM_SUB      6
`define OSR_SEL_CAL      3'h0
`define OSR_SEL_MEAS     3'h1
`define OSR_SEL_TRIG     3'h2
`define OSR_SEL_INIT     3'h3
`define OSR_SEL_BELOW    3'h4
`define OSR_SEL_ABOVE    3'h5
`define OSR_SUM_CAL      0
`define OSR_SUM_MEAS     4
`define OSR_SUM_TRIG     5
`define OSR_SUM_INIT     10
`define OSR_SUM_BELOW    11
`define OSR_SUM_ABOVE    12
`define OSR_PTR_RESET    6'h3F
`define OSR_NTR_RESET    6'h00
`define OSR_INIT_CYCLES  16'h0010
`endif

// [src/osr_pkg.sv]
// types for the operation sub-status register bank
package osr_pkg;
  typedef enum logic [4:0] {
    OSR_ST_INIT = 5'b00001,
    OSR_ST_IDLE = 5'b00010,
    OSR_ST_WAIT = 5'b00100,
    OSR_ST_MEAS = 5'b01000,
    OSR_ST_CAL  = 5'b10000
  } osr_state_type;

  typedef struct packed {
    logic       rd;
    logic [2:0] sel;
    logic       event_view;
  } osr_query_type;

  typedef struct packed {
    logic [5:0] ptr;
    logic [5:0] ntr;
  } osr_filter_type;
endpackage

// [src/osr_event_bit.sv]
// one filtered, read-clear event latch for a single condition
`timescale 1ns/1ps
`default_nettype none
`include "osr_params.svh"
module osr_event_bit (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  // condition and filter
  input  wire logic cond_i,
  input  wire logic ptr_i,
  input  wire logic ntr_i,
  // readout
  input  wire logic clear_i,
  // state
  output var  logic event_o
);
  logic cond_reg;
  logic hit;

  // only edges that the filter lets through are recorded
  assign hit = (ptr_i & cond_i & ~cond_reg) | (ntr_i & ~cond_i & cond_reg);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cond_reg <= 1'b0;
    end else begin
      cond_reg <= cond_i;
    end
  end

  // set wins over the clear of a readout
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      event_o <= 1'b0;
    end else if (hit) begin
      event_o <= 1'b1;
    end else if (clear_i) begin
      event_o <= 1'b0;
    end
  end

  property p_event_hit;
    @(posedge core_clk_i) disable iff (!rstn_i) hit |=> event_o;
  endproperty
  a_event_hit: assert property (p_event_hit) else $error("filtered edge lost");

  property p_event_clear;
    @(posedge core_clk_i) disable iff (!rstn_i) (clear_i && !hit) |=> !event_o;
  endproperty
  a_event_clear: assert property (p_event_clear) else $error("read did not clear");
endmodule
`default_nettype wire

// [src/osr_init_timer.sv]
// counts out the initialization period after each start request
`timescale 1ns/1ps
`default_nettype none
`include "osr_params.svh"
module osr_init_timer #(
  parameter logic [15:0] INIT_CYCLES = `OSR_INIT_CYCLES
) (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  // control
  input  wire logic start_i,
  // status
  output var  logic done_o
);
  logic [15:0] cnt_reg;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg <= 16'h0000;
      done_o  <= 1'b0;
    end else if (start_i) begin
      cnt_reg <= 16'h0000;
      done_o  <= 1'b0;
    end else if (cnt_reg == INIT_CYCLES - 16'h0001) begin
      done_o  <= 1'b1;
    end else if (!done_o) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// [src/osr_status_bank.sv]
// operation sub-status condition and event views with the sensor state sequencer
`timescale 1ns/1ps
`default_nettype none
`include "osr_params.svh"
module osr_status_bank #(
  parameter logic [15:0] INIT_CYCLES = `OSR_INIT_CYCLES
) (
  // clock and reset
  input  wire logic                   core_clk_i,
  input  wire logic                   rstn_i,
  // sensor activity
  input  wire logic                   sensor_connect_i,
  input  wire logic                   default_restore_i,
  input  wire logic                   preset_restore_i,
  input  wire logic                   cal_start_i,
  input  wire logic                   cal_done_i,
  input  wire logic                   arm_i,
  input  wire logic                   trigger_i,
  input  wire logic                   meas_done_i,
  input  wire logic                   below_limit_i,
  input  wire logic                   above_limit_i,
  // transition filter configuration
  input  wire osr_pkg::osr_filter_type filter_i,
  // query port
  input  wire osr_pkg::osr_query_type  query_i,
  output logic [`OSR_REG_W-1:0]       rdata_o,
  output logic                        rvalid_o,
  // summaries for the parent operation register, and the sequencer state
  output logic [`OSR_REG_W-1:0]       oper_cond_o,
  output logic [`OSR_REG_W-1:0]       oper_event_o,
  output osr_pkg::osr_state_type      state_o
);
  osr_pkg::osr_state_type state_reg;
  osr_pkg::osr_state_type state_next;
  logic [5:0]             cond;
  logic [5:0]             events;
  logic [5:0]             clear;
  logic                   init_req;
  logic                   init_done;
  logic                   pwr_up_reg;
  logic [`OSR_REG_W-1:0]  rdata_next;
  osr_pkg::osr_filter_type filt;

  // filter settings come straight from the configuration port
  assign filt = filter_i;

  // power-up, connect and both restore commands begin initialization
  assign init_req = pwr_up_reg | sensor_connect_i | default_restore_i | preset_restore_i;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pwr_up_reg <= 1'b1;
    end else begin
      pwr_up_reg <= 1'b0;
    end
  end

  osr_init_timer #(
    .INIT_CYCLES(INIT_CYCLES)
  ) u_init_timer (
    .core_clk_i(core_clk_i),
    .rstn_i    (rstn_i),
    .start_i   (init_req),
    .done_o    (init_done)
  );

  always_comb begin
    state_next = state_reg;
    if (init_req) begin
      state_next = osr_pkg::OSR_ST_INIT;
    end else begin
      unique case (state_reg)
        osr_pkg::OSR_ST_INIT: begin
          if (init_done) state_next = osr_pkg::OSR_ST_IDLE;
        end
        osr_pkg::OSR_ST_IDLE: begin
          if (cal_start_i) state_next = osr_pkg::OSR_ST_CAL;
          else if (arm_i) state_next = osr_pkg::OSR_ST_WAIT;
        end
        osr_pkg::OSR_ST_WAIT: begin
          if (trigger_i) state_next = osr_pkg::OSR_ST_MEAS;
        end
        osr_pkg::OSR_ST_MEAS: begin
          if (meas_done_i) state_next = osr_pkg::OSR_ST_IDLE;
        end
        osr_pkg::OSR_ST_CAL: begin
          if (cal_done_i) state_next = osr_pkg::OSR_ST_IDLE;
        end
        default: state_next = osr_pkg::OSR_ST_INIT;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= osr_pkg::OSR_ST_INIT;
    end else begin
      state_reg <= state_next;
    end
  end

  // live conditions, indexed by register select
  assign cond[`OSR_SEL_CAL]   = (state_reg == osr_pkg::OSR_ST_CAL);
  assign cond[`OSR_SEL_MEAS]  = (state_reg == osr_pkg::OSR_ST_MEAS);
  assign cond[`OSR_SEL_TRIG]  = (state_reg == osr_pkg::OSR_ST_WAIT);
  assign cond[`OSR_SEL_INIT]  = (state_reg == osr_pkg::OSR_ST_INIT);
  assign cond[`OSR_SEL_BELOW] = below_limit_i;
  assign cond[`OSR_SEL_ABOVE] = above_limit_i;

  genvar gi;
  generate
    for (gi = 0; gi < `OSR_NUM_SUB; gi = gi + 1) begin : g_evt
      assign clear[gi] = query_i.rd & query_i.event_view & (query_i.sel == 3'(gi));
      osr_event_bit u_evt (
        .core_clk_i(core_clk_i),
        .rstn_i    (rstn_i),
        .cond_i    (cond[gi]),
        .ptr_i     (filt.ptr[gi]),
        .ntr_i     (filt.ntr[gi]),
        .clear_i   (clear[gi]),
        .event_o   (events[gi])
      );
    end
  endgenerate

  // only bit 1 is ever populated
  always_comb begin
    rdata_next = '0;
    if (query_i.sel < 3'(`OSR_NUM_SUB)) begin
      if (query_i.event_view) begin
        rdata_next[`OSR_ACTIVE_BIT] = events[query_i.sel];
      end else begin
        rdata_next[`OSR_ACTIVE_BIT] = cond[query_i.sel];
      end
    end
  end

  // readout captures the value before the clear lands
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o  <= 16'h0000;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= query_i.rd;
      if (query_i.rd) rdata_o <= rdata_next;
    end
  end

  // summaries into the parent operation register
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      oper_cond_o  <= 16'h0000;
      oper_event_o <= 16'h0000;
    end else begin
      oper_cond_o  <= '0;
      oper_event_o <= '0;
      oper_cond_o[`OSR_SUM_CAL]    <= cond[`OSR_SEL_CAL];
      oper_cond_o[`OSR_SUM_MEAS]   <= cond[`OSR_SEL_MEAS];
      oper_cond_o[`OSR_SUM_TRIG]   <= cond[`OSR_SEL_TRIG];
      oper_cond_o[`OSR_SUM_INIT]   <= cond[`OSR_SEL_INIT];
      oper_cond_o[`OSR_SUM_BELOW]  <= cond[`OSR_SEL_BELOW];
      oper_cond_o[`OSR_SUM_ABOVE]  <= cond[`OSR_SEL_ABOVE];
      oper_event_o[`OSR_SUM_CAL]   <= events[`OSR_SEL_CAL];
      oper_event_o[`OSR_SUM_MEAS]  <= events[`OSR_SEL_MEAS];
      oper_event_o[`OSR_SUM_TRIG]  <= events[`OSR_SEL_TRIG];
      oper_event_o[`OSR_SUM_INIT]  <= events[`OSR_SEL_INIT];
      oper_event_o[`OSR_SUM_BELOW] <= events[`OSR_SEL_BELOW];
      oper_event_o[`OSR_SUM_ABOVE] <= events[`OSR_SEL_ABOVE];
    end
  end

  assign state_o = state_reg;

  sequence s_waiting_trig;
    (state_reg == osr_pkg::OSR_ST_WAIT) && trigger_i && !init_req;
  endsequence
  property p_trig_to_meas;
    @(posedge core_clk_i) disable iff (!rstn_i)
      s_waiting_trig |=> state_reg == osr_pkg::OSR_ST_MEAS;
  endproperty
  a_trig_to_meas: assert property (p_trig_to_meas) else $error("trigger missed");

  property p_init_entry;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (default_restore_i || preset_restore_i || sensor_connect_i) |=> cond[`OSR_SEL_INIT];
  endproperty
  a_init_entry: assert property (p_init_entry) else $error("no init entry");

  property p_cal_cond;
    @(posedge core_clk_i) disable iff (!rstn_i)
      ((state_reg == osr_pkg::OSR_ST_IDLE) && cal_start_i && !init_req)
      |=> cond[`OSR_SEL_CAL];
  endproperty
  a_cal_cond: assert property (p_cal_cond) else $error("cal view wrong");

  property p_meas_read;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (query_i.rd && !query_i.event_view && query_i.sel == `OSR_SEL_MEAS)
      |=> rdata_o[`OSR_ACTIVE_BIT] == $past(cond[`OSR_SEL_MEAS]);
  endproperty
  a_meas_read: assert property (p_meas_read) else $error("meas read wrong");

  property p_unused_zero;
    @(posedge core_clk_i) disable iff (!rstn_i)
      rvalid_o |-> (rdata_o & ~16'h0002) == 16'h0000;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

  property p_trig_summary;
    @(posedge core_clk_i) disable iff (!rstn_i)
      cond[`OSR_SEL_TRIG] |=> oper_cond_o[`OSR_SUM_TRIG];
  endproperty
  a_trig_summary: assert property (p_trig_summary) else $error("trig summary");

  property p_above_cond;
    @(posedge core_clk_i) disable iff (!rstn_i)
      above_limit_i |=> oper_cond_o[`OSR_SUM_ABOVE];
  endproperty
  a_above_cond: assert property (p_above_cond) else $error("above summary");

  property p_below_event;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (filt.ptr[`OSR_SEL_BELOW] && $rose(below_limit_i)) |=> ##1 oper_event_o[`OSR_SUM_BELOW];
  endproperty
  a_below_event: assert property (p_below_event) else $error("below event lost");
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench for the operation sub-status register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [15:0] INIT_N = 16'h0004;
  logic                    core_clk_i;
  logic                    rstn_i;
  logic [7:0]              pls;
  logic                    below;
  logic                    above;
  osr_pkg::osr_filter_type flt;
  osr_pkg::osr_query_type  qry;
  logic [15:0]             rdata;
  logic                    rvalid;
  logic [15:0]             ocond;
  logic [15:0]             oevent;
  osr_pkg::osr_state_type  state;
  logic [15:0]             d;
  logic [15:0]             d2;
  int                      n_fail;
  int                      total_checks;

  osr_status_bank #(.INIT_CYCLES(INIT_N)) dut (
    .core_clk_i        (core_clk_i),
    .rstn_i            (rstn_i),
    .sensor_connect_i  (pls[0]),
    .default_restore_i (pls[1]),
    .preset_restore_i  (pls[2]),
    .cal_start_i       (pls[3]),
    .cal_done_i        (pls[4]),
    .arm_i             (pls[5]),
    .trigger_i         (pls[6]),
    .meas_done_i       (pls[7]),
    .below_limit_i     (below),
    .above_limit_i     (above),
    .filter_i          (flt),
    .query_i           (qry),
    .rdata_o           (rdata),
    .rvalid_o          (rvalid),
    .oper_cond_o       (ocond),
    .oper_event_o      (oevent),
    .state_o           (state)
  );

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_st(input string what, input osr_pkg::osr_state_type exp);
    total_checks++;
    if (state !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %b seen %b", what, exp, state);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  // one-cycle high pulse on an activity input
  task automatic pulse(input int b);
    pls[b] = 1'b1;
    wait_n(1);
    pls[b] = 1'b0;
    wait_n(1);
  endtask

  // request taken at the next edge, answer one cycle later
  task automatic do_read(input logic [2:0] sel, input logic ev, output logic [15:0] val);
    qry = '{rd: 1'b1, sel: sel, event_view: ev};
    wait_n(1);
    // rvalid stands only in the cycle after the request edge
    chk("rvalid", 16'h0001, {15'h0000, rvalid});
    chk("unused bits", 16'h0000, rdata & 16'hFFFD);
    val = rdata;
    qry.rd = 1'b0;
    wait_n(1);
  endtask

  task automatic t_init();
    chk_st("state after reset", osr_pkg::OSR_ST_INIT);
    do_read(3'h3, 1'b0, d);
    chk("init condition", 16'h0002, d);
    chk("init summary", 16'h0400, ocond);
    wait_n(int'(INIT_N) + 6);
    chk_st("state after init", osr_pkg::OSR_ST_IDLE);
    do_read(3'h3, 1'b0, d);
    chk("init condition done", 16'h0000, d);
    do_read(3'h3, 1'b1, d);
    chk("init event", 16'h0002, d);
    do_read(3'h3, 1'b1, d);
    chk("init event reread", 16'h0000, d);
  endtask

  task automatic t_cal();
    pulse(3);
    wait_n(2);
    chk_st("calibrating", osr_pkg::OSR_ST_CAL);
    chk("cal summary", 16'h0001, ocond);
    do_read(3'h0, 1'b0, d);
    chk("cal condition", 16'h0002, d);
    pulse(4);
    wait_n(2);
    do_read(3'h0, 1'b0, d);
    chk("cal condition done", 16'h0000, d);
    chk("cal event summary", 16'h0001, oevent & 16'h0001);
    do_read(3'h0, 1'b1, d);
    chk("cal event", 16'h0002, d);
  endtask

  task automatic t_trig();
    pulse(5);
    wait_n(2);
    chk_st("waiting", osr_pkg::OSR_ST_WAIT);
    chk("trigger summary", 16'h0020, ocond);
    do_read(3'h2, 1'b0, d);
    chk("trigger condition", 16'h0002, d);
    pulse(6);
    wait_n(2);
    chk_st("measuring after trigger", osr_pkg::OSR_ST_MEAS);
    chk("meas summary", 16'h0010, ocond);
    do_read(3'h1, 1'b0, d);
    chk("meas condition", 16'h0002, d);
    do_read(3'h2, 1'b0, d);
    chk("trigger condition left", 16'h0000, d);
    do_read(3'h2, 1'b1, d);
    chk("trigger event", 16'h0002, d);
    pulse(7);
    wait_n(2);
    do_read(3'h1, 1'b0, d);
    chk("meas condition done", 16'h0000, d);
    do_read(3'h1, 1'b1, d);
    chk("meas event", 16'h0002, d);
  endtask

  task automatic t_limits();
    for (int i = 0; i < 2; i++) begin
      below = (i == 0);
      above = (i == 1);
      wait_n(3);
      chk("limit summary", (i == 0) ? 16'h0800 : 16'h1000, ocond);
      do_read(3'(4 + i), 1'b0, d);
      chk("limit condition", 16'h0002, d);
      below = 1'b0;
      above = 1'b0;
      wait_n(3);
      do_read(3'(4 + i), 1'b1, d);
      chk("limit event", 16'h0002, d);
    end
    flt.ptr[4] = 1'b0;
    wait_n(1);
    below = 1'b1;
    wait_n(3);
    do_read(3'h4, 1'b1, d);
    chk("rising edge filtered out", 16'h0000, d);
    below = 1'b0;
    wait_n(3);
    do_read(3'h4, 1'b1, d);
    chk("falling edge kept", 16'h0002, d);
    flt.ptr[4] = 1'b1;
  endtask

  // each commanded init request (connect, default restore, preset restore), issued while calibrating, restarts initialization
  task automatic t_restore();
    for (int b = 0; b < 3; b++) begin
      pulse(3);
      pulse(b);
      chk_st("init on request", osr_pkg::OSR_ST_INIT);
      wait_n(int'(INIT_N) + 6);
      chk_st("idle after init", osr_pkg::OSR_ST_IDLE);
      do_read(3'h3, 1'b1, d);
      chk("init event after request", 16'h0002, d);
    end
  endtask

  task automatic t_misc();
    do_read(3'h6, 1'b0, d);
    chk("unmapped select", 16'h0000, d);
    do_read(3'h7, 1'b1, d);
    chk("unmapped select event", 16'h0000, d);
    do_read(3'h5, 1'b1, d);
    // edge lands while the clearing read is under way
    above = 1'b1;
    do_read(3'h5, 1'b1, d);
    do_read(3'h5, 1'b1, d2);
    chk("edge during read kept", 16'h0002, d | d2);
    above = 1'b0;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end

  initial begin
    n_fail = 0;
    total_checks = 0;
    rstn_i = 1'b0;
    pls = 8'h00;
    below = 1'b0;
    above = 1'b0;
    flt = '{ptr: 6'h3F, ntr: 6'h3F};
    qry = '{rd: 1'b0, sel: 3'h0, event_view: 1'b0};
    repeat (6) @(negedge core_clk_i);
    rstn_i = 1'b1;
    t_init();
    t_cal();
    t_trig();
    t_limits();
    t_restore();
    t_misc();
    report_and_stop();
  end

  // cut a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_fail++;
    report_and_stop();
  end
endmodule
`default_nettype wire
